// >>> rtl/exec_defs.sv
// Shared constants for the execution unit and its byte multiplier
`timescale 1ns/100ps
// Function
// - Table load adds accumulator to 16-bit base
// - Program-counter base advanced first; pointer base kept
// - Full 16-bit address add, flags untouched
// - External move carries one accumulator byte
// - Short form: bank index register, low port
// - Long form: pointer high and low ports
// - High port latch unchanged during long access
// - Multiply: low byte accumulator, high auxiliary
// - Overflow set when product exceeds 255
// - Multiply always clears carry
// - No-operation only advances program counter
// - Byte OR writes result, flags untouched unless the destination is the status byte
// - Six operand forms for byte OR
// - Port OR reads output latch, not pins
package exec_defs_pkg;
    localparam logic [7:0]  OP_NO_OPERATION  = 8'h00;
    localparam logic [7:0]  OP_TABLE_PTR     = 8'h93;
    localparam logic [7:0]  OP_TABLE_PC      = 8'h83;
    localparam logic [7:0]  OP_XRD_PTR       = 8'hE0;
    localparam logic [6:0]  OP_XRD_IDX       = 7'h71;
    localparam logic [7:0]  OP_XWR_PTR       = 8'hF0;
    localparam logic [6:0]  OP_XWR_IDX       = 7'h79;
    localparam logic [7:0]  OP_MULTIPLY      = 8'hA4;
    localparam logic [4:0]  OP_OR_ACC_REG    = 5'h09;
    localparam logic [7:0]  OP_OR_ACC_DIR    = 8'h45;
    localparam logic [6:0]  OP_OR_ACC_IND    = 7'h23;
    localparam logic [7:0]  OP_OR_ACC_IMM    = 8'h44;
    localparam logic [7:0]  OP_OR_DIR_ACC    = 8'h42;
    localparam logic [7:0]  OP_OR_DIR_IMM    = 8'h43;
    localparam logic [7:0]  SFR_LOW_PORT     = 8'h80;
    localparam logic [7:0]  SFR_PTR_LOW      = 8'h82;
    localparam logic [7:0]  SFR_PTR_HIGH     = 8'h83;
    localparam logic [7:0]  SFR_HIGH_PORT    = 8'hA0;
    localparam logic [7:0]  SFR_ACC          = 8'hE0;
    localparam logic [7:0]  SFR_AUX          = 8'hF0;
    localparam logic [7:0]  SFR_STATUS       = 8'hD0;
    localparam int          CARRY_BIT        = 7;
    localparam int          OVER_BIT         = 2;
    localparam logic [7:0]  PORT_LATCH_RESET = 8'hFF;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [7:0]  PRODUCT_LIMIT    = 8'hFF;
    localparam logic [1:0]  EXT_DATA_CYCLES  = 2'h3;

    // Instruction length in bytes for the supported opcodes
    function automatic logic [15:0] instrLength(input logic [7:0] op);
        if (op == OP_OR_DIR_IMM) begin
            return 16'h0003;
        end else if (op == OP_OR_ACC_DIR || op == OP_OR_ACC_IMM ||
                     op == OP_OR_DIR_ACC) begin
            return 16'h0002;
        end else begin
            return 16'h0001;
        end
    endfunction : instrLength
endpackage : exec_defs_pkg

// Unsigned byte multiplier
module byte_multiplier (
    // Operands
    input  wire logic [7:0]  factorA,
    input  wire logic [7:0]  factorB,
    // Result
    output logic      [15:0] product,
    output logic             overLimit
);
    assign product   = {8'h00, factorA} * {8'h00, factorB};
    assign overLimit = product > {8'h00, exec_defs_pkg::PRODUCT_LIMIT};
endmodule : byte_multiplier

// >>> rtl/code_ext_mul_or_exec.sv
`timescale 1ns/100ps
// Execution unit for table load, external move, multiply, nop and byte OR
module code_ext_mul_or_exec (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Instruction issue
    input  wire logic        instrValid,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand1,
    input  wire logic [7:0]  operand2,
    input  wire logic [1:0]  regBank,
    output logic             instrReady,
    output logic             instrDone,
    // Program memory
    output logic      [15:0] codeAddr,
    output logic             codeRead,
    input  wire logic [7:0]  codeData,
    input  wire logic        codeValid,
    // External data bus
    output logic      [7:0]  lowMuxPortOut,
    output logic             lowMuxPortOe,
    input  wire logic [7:0]  lowMuxPortIn,
    output logic      [7:0]  highAddressPortOut,
    output logic             addrLatchStrobe,
    output logic             extReadStrobe,
    output logic             extWriteStrobe,
    // Visible state
    output logic      [7:0]  acc,
    output logic      [7:0]  auxReg,
    output logic      [15:0] pc,
    output logic      [15:0] dataPointer,
    output logic             carryFlag,
    output logic             overflowFlag,
    output logic      [7:0]  lowPortLatch,
    output logic      [7:0]  highPortLatch
);
    typedef enum logic [2:0] {
        IDLE, CODE_WAIT, EXT_ADDR, EXT_DATA
    } state_t;

    state_t      state;
    logic [7:0]  ram [0:127];
    logic [7:0]  pinSync1;
    logic [7:0]  pinSync2;
    logic        extWrite;
    logic [15:0] extAddr;
    logic [1:0]  dataCount;

    // Decode
    wire isTblPtr = opcode == exec_defs_pkg::OP_TABLE_PTR;
    wire isTblPc  = opcode == exec_defs_pkg::OP_TABLE_PC;
    wire isMul    = opcode == exec_defs_pkg::OP_MULTIPLY;
    wire isXrdPtr = opcode == exec_defs_pkg::OP_XRD_PTR;
    wire isXwrPtr = opcode == exec_defs_pkg::OP_XWR_PTR;
    wire isXrdIdx = opcode[7:1] == exec_defs_pkg::OP_XRD_IDX;
    wire isXwrIdx = opcode[7:1] == exec_defs_pkg::OP_XWR_IDX;
    wire isOrReg  = opcode[7:3] == exec_defs_pkg::OP_OR_ACC_REG;
    wire isOrDir  = opcode == exec_defs_pkg::OP_OR_ACC_DIR;
    wire isOrInd  = opcode[7:1] == exec_defs_pkg::OP_OR_ACC_IND;
    wire isOrImm  = opcode == exec_defs_pkg::OP_OR_ACC_IMM;
    wire isOrDA   = opcode == exec_defs_pkg::OP_OR_DIR_ACC;
    wire isOrDI   = opcode == exec_defs_pkg::OP_OR_DIR_IMM;
    wire isOrAcc  = isOrReg | isOrDir | isOrInd | isOrImm;
    wire isOrMem  = isOrDA | isOrDI;
    wire isXmove  = isXrdPtr | isXwrPtr | isXrdIdx | isXwrIdx;
    wire isTable  = isTblPtr | isTblPc;
    wire start    = instrValid && state == IDLE;

    // Operand fetch
    wire [7:0]  indexValue = ram[{2'b00, regBank, 2'b00, opcode[0]}];
    wire [7:0]  regValue   = ram[{2'b00, regBank, opcode[2:0]}];
    wire [7:0]  indValue   = ram[indexValue[6:0]];
    // Direct address selects
    wire        atLowPort  = operand1 == exec_defs_pkg::SFR_LOW_PORT;
    wire        atHighPort = operand1 == exec_defs_pkg::SFR_HIGH_PORT;
    wire        atPtrLow   = operand1 == exec_defs_pkg::SFR_PTR_LOW;
    wire        atPtrHigh  = operand1 == exec_defs_pkg::SFR_PTR_HIGH;
    wire        atAcc      = operand1 == exec_defs_pkg::SFR_ACC;
    wire        atAux      = operand1 == exec_defs_pkg::SFR_AUX;
    wire        atStatus   = operand1 == exec_defs_pkg::SFR_STATUS;
    // Flag byte as direct addressing sees it
    wire [7:0]  carryMask  = 8'h01 << exec_defs_pkg::CARRY_BIT;
    wire [7:0]  overMask   = 8'h01 << exec_defs_pkg::OVER_BIT;
    wire [7:0]  statusByte = (carryFlag ? carryMask : 8'h00) |
                             (overflowFlag ? overMask : 8'h00);
    // Port OR sees the output latch, never the pins
    wire [7:0]  directValue =
        !operand1[7] ? ram[operand1[6:0]] :
        atLowPort    ? lowPortLatch :
        atHighPort   ? highPortLatch :
        atPtrLow     ? dataPointer[7:0] :
        atPtrHigh    ? dataPointer[15:8] :
        atAcc        ? acc :
        atAux        ? auxReg :
        atStatus     ? statusByte :
        exec_defs_pkg::BYTE_RESET;
    wire [7:0]  orSource =
        isOrReg ? regValue : isOrDir ? directValue :
        isOrInd ? indValue : isOrImm ? operand1 :
        isOrDA  ? acc : operand2;
    wire [7:0]  orResult = (isOrMem ? directValue : acc) | orSource;
    wire        dirWrite = start && isOrMem;
    wire [15:0] nextPc   = pc + exec_defs_pkg::instrLength(opcode);
    wire [15:0] tableBase = isTblPc ? pc + 16'h0001 : dataPointer;
    wire [15:0] tableAddr = tableBase + {8'h00, acc};
    wire        dataLast = dataCount == exec_defs_pkg::EXT_DATA_CYCLES;
    wire [15:0] product;
    wire        overLimit;

    byte_multiplier mult (
        .factorA   (acc),
        .factorB   (auxReg),
        .product   (product),
        .overLimit (overLimit)
    );

    assign instrReady = state == IDLE;

    // Pin synchroniser
    always_ff @(posedge clk) begin
        pinSync1 <= lowMuxPortIn;
        pinSync2 <= pinSync1;
    end

    // Internal data memory
    always_ff @(posedge clk) begin
        if (dirWrite && !operand1[7]) begin
            ram[operand1[6:0]] <= orResult;
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
            acc <= exec_defs_pkg::BYTE_RESET;
            auxReg <= exec_defs_pkg::BYTE_RESET;
            pc <= exec_defs_pkg::WORD_RESET;
            dataPointer <= exec_defs_pkg::WORD_RESET;
            carryFlag <= 1'b0;
            overflowFlag <= 1'b0;
            lowPortLatch <= exec_defs_pkg::PORT_LATCH_RESET;
            highPortLatch <= exec_defs_pkg::PORT_LATCH_RESET;
            instrDone <= 1'b0;
            codeAddr <= exec_defs_pkg::WORD_RESET;
            codeRead <= 1'b0;
            lowMuxPortOut <= exec_defs_pkg::PORT_LATCH_RESET;
            lowMuxPortOe <= 1'b1;
            highAddressPortOut <= exec_defs_pkg::PORT_LATCH_RESET;
            addrLatchStrobe <= 1'b0;
            extReadStrobe <= 1'b0;
            extWriteStrobe <= 1'b0;
            extWrite <= 1'b0;
            extAddr <= exec_defs_pkg::WORD_RESET;
            dataCount <= 2'h0;
        end else begin
            instrDone <= 1'b0;
            codeRead <= 1'b0;
            addrLatchStrobe <= 1'b0;
            case (state)
                IDLE: begin
                    lowMuxPortOut <= lowPortLatch;
                    lowMuxPortOe <= 1'b1;
                    highAddressPortOut <= highPortLatch;
                    if (start) begin
                        if (isTable) begin
                            codeAddr <= tableAddr;
                            codeRead <= 1'b1;
                            state <= CODE_WAIT;
                        end else if (isXmove) begin
                            extWrite <= isXwrPtr | isXwrIdx;
                            extAddr <= (isXrdPtr | isXwrPtr) ? dataPointer
                                : {highPortLatch, indexValue};
                            state <= EXT_ADDR;
                        end else begin
                            pc <= nextPc;
                            instrDone <= 1'b1;
                            if (isMul) begin
                                acc <= product[7:0];
                                auxReg <= product[15:8];
                                overflowFlag <= overLimit;
                                carryFlag <= 1'b0;
                            end else if (isOrAcc) begin
                                acc <= orResult;
                            end else if (dirWrite) begin
                                if (atLowPort) begin
                                    lowPortLatch <= orResult;
                                end else if (atHighPort) begin
                                    highPortLatch <= orResult;
                                end else if (atPtrLow) begin
                                    dataPointer[7:0] <= orResult;
                                end else if (atPtrHigh) begin
                                    dataPointer[15:8] <= orResult;
                                end else if (atAcc) begin
                                    acc <= orResult;
                                end else if (atAux) begin
                                    auxReg <= orResult;
                                end else if (atStatus) begin
                                    carryFlag <= |(orResult & carryMask);
                                    overflowFlag <= |(orResult & overMask);
                                end
                            end
                        end
                    end
                end
                CODE_WAIT: begin
                    if (codeValid) begin
                        acc <= codeData;
                        pc <= pc + 16'h0001;
                        instrDone <= 1'b1;
                        state <= IDLE;
                    end
                end
                EXT_ADDR: begin
                    // Low address leads, high port shows the address high byte
                    lowMuxPortOut <= extAddr[7:0];
                    lowMuxPortOe <= 1'b1;
                    highAddressPortOut <= extAddr[15:8];
                    addrLatchStrobe <= 1'b1;
                    // Three strobe cycles let the pin synchroniser settle
                    dataCount <= 2'h0;
                    state <= EXT_DATA;
                end
                EXT_DATA: begin
                    lowMuxPortOut <= extWrite ? acc : lowPortLatch;
                    lowMuxPortOe <= extWrite;
                    extWriteStrobe <= extWrite && !dataLast;
                    extReadStrobe <= !extWrite && !dataLast;
                    dataCount <= dataCount + 2'h1;
                    if (dataLast) begin
                        if (!extWrite) begin
                            acc <= pinSync2;
                        end
                        pc <= pc + 16'h0001;
                        instrDone <= 1'b1;
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule : code_ext_mul_or_exec

// >>> tb/exec_props.sv
// Port checker for the execution unit
`timescale 1ns/100ps
module exec_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Issue and state
    input wire logic        instrValid,
    input wire logic        instrReady,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  auxReg,
    input wire logic [15:0] pc,
    input wire logic [15:0] dataPointer,
    input wire logic        carryFlag,
    input wire logic        overflowFlag,
    input wire logic [7:0]  highPortLatch,
    // Buses
    input wire logic        codeRead,
    input wire logic [15:0] codeAddr,
    input wire logic [7:0]  lowMuxPortOut,
    input wire logic        lowMuxPortOe,
    input wire logic [7:0]  highAddressPortOut,
    input wire logic        addrLatchStrobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire        tk    = instrValid && instrReady;
    wire [15:0] prod  = acc * auxReg;
    wire [15:0] ext   = {8'h00, acc};
    wire        isExt = tk && opcode[7:5] == 3'h7 && opcode[3:2] == 2'h0
                        && opcode[1:0] != 2'h1;
    sequence addrOut;
        ##2 addrLatchStrobe && lowMuxPortOe;
    endsequence
    mul_prod_a : assert property (
        tk && opcode == 8'hA4 |=> {auxReg, acc} == $past(prod) && !carryFlag)
        else $error("multiply product or carry wrong");
    mul_ovf_a : assert property (
        tk && opcode == 8'hA4 |=> overflowFlag == ($past(prod) > 16'h00FF))
        else $error("multiply overflow wrong");
    nop_pc_a : assert property (
        tk && opcode == 8'h00 |=> pc == $past(pc) + 16'h0001
        && $stable(acc) && $stable(auxReg) && $stable(dataPointer))
        else $error("no-operation changed state");
    tbl_ptr_a : assert property (
        tk && opcode == 8'h93 |=> codeRead && $stable(dataPointer)
        && codeAddr == $past(dataPointer) + $past(ext))
        else $error("pointer table address wrong");
    tbl_pc_a : assert property (
        tk && opcode == 8'h83 |=> codeAddr == $past(pc) + 16'h0001 + $past(ext))
        else $error("counter table address wrong");
    long_addr_a : assert property (
        isExt && !opcode[1] |-> addrOut
        ##0 {highAddressPortOut, lowMuxPortOut} == $past(dataPointer, 2))
        else $error("pointer address not on ports");
    short_addr_a : assert property (
        isExt && opcode[1] |-> addrOut
        ##0 highAddressPortOut == $past(highPortLatch, 2))
        else $error("short form high byte wrong");
    hold_latch_a : assert property (
        isExt |=> $stable(highPortLatch)[*5])
        else $error("high port latch changed by move");
endmodule : exec_props

// >>> tb/ext_partner.sv
// Program memory and external data RAM model
`timescale 1ns/100ps
module ext_partner (
    // Clock and pace
    input  wire logic        clk,
    input  wire logic        slow,
    // Program memory
    input  wire logic        codeRead,
    input  wire logic [15:0] codeAddr,
    output logic      [7:0]  codeData,
    output logic             codeValid,
    // External data bus
    input  wire logic [7:0]  lowMuxPortOut,
    input  wire logic        lowMuxPortOe,
    output logic      [7:0]  lowMuxPortIn,
    input  wire logic [7:0]  highAddressPortOut,
    input  wire logic        addrLatchStrobe,
    input  wire logic        extReadStrobe,
    input  wire logic        extWriteStrobe
);
    logic [7:0]  ram [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [15:0] cAddr = 16'h0000;
    logic [2:0]  waitCnt = 3'h0;
    logic        rdLate = 1'b0;
    wire  [7:0]  rom = cAddr[15:8] ^ cAddr[7:0] ^ 8'h5A;
    wire         rdOn = extReadStrobe || rdLate;
    assign codeValid = waitCnt == 3'h1;
    assign codeData = codeValid ? rom : ~rom;
    assign lowMuxPortIn = lowMuxPortOe ? lowMuxPortOut
                        : rdOn ? ram[addr] : ~ram[addr];
    always @(posedge clk) begin
        rdLate <= extReadStrobe;
        if (codeRead) begin
            cAddr <= codeAddr;
            waitCnt <= slow ? 3'h5 : 3'h1;
        end else if (waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
        end
        if (addrLatchStrobe) begin
            addr <= {highAddressPortOut, lowMuxPortOut};
        end
        if (extWriteStrobe) begin
            ram[addr] <= lowMuxPortOut;
        end
    end
endmodule : ext_partner

// >>> tb/tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        instrValid = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  regBank = 2'h0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  operand1 = 8'h00;
    logic [7:0]  operand2 = 8'h00;
    logic        instrReady, instrDone, codeRead, codeValid, lowMuxPortOe;
    logic        addrLatchStrobe, extReadStrobe, extWriteStrobe;
    logic        carryFlag, overflowFlag;
    logic [15:0] codeAddr, pc, dataPointer;
    logic [7:0]  codeData, lowMuxPortOut, lowMuxPortIn, highAddressPortOut;
    logic [7:0]  acc, auxReg, lowPortLatch, highPortLatch, eAcc;
    logic [15:0] ePc = 16'h0000;
    logic [15:0] t;
    int          failCount = 0;
    int          totalChecks = 0;
    int          cycles = 0;
    code_ext_mul_or_exec dut (.clk, .srst, .instrValid, .opcode, .operand1,
        .operand2, .regBank, .instrReady, .instrDone, .codeAddr,
        .codeRead, .codeData, .codeValid, .lowMuxPortOut, .lowMuxPortOe,
        .lowMuxPortIn, .highAddressPortOut, .addrLatchStrobe, .extReadStrobe,
        .extWriteStrobe, .acc, .auxReg, .pc, .dataPointer, .carryFlag,
        .overflowFlag, .lowPortLatch, .highPortLatch);
    ext_partner mem (.clk, .slow, .codeRead, .codeAddr, .codeData,
        .codeValid, .lowMuxPortOut, .lowMuxPortOe, .lowMuxPortIn,
        .highAddressPortOut, .addrLatchStrobe, .extReadStrobe,
        .extWriteStrobe);
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] s, e);
        totalChecks++;
        if (s !== e) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic run(input logic [7:0] op, a = 8'h00, b = 8'h00);
        opcode = op;
        operand1 = a;
        operand2 = b;
        instrValid = 1'b1;
        @(negedge clk);
        instrValid = 1'b0;
        while (instrDone !== 1'b1) begin
            @(negedge clk);
        end
        ePc += (op == 8'h43) ? 16'h0003
             : (op inside {8'h42, 8'h44, 8'h45}) ? 16'h0002 : 16'h0001;
        @(negedge clk);
    endtask : run
    task automatic tMul();
        run(8'h43, 8'hE0, 8'h50);
        run(8'h43, 8'hF0, 8'hA0);
        run(8'h43, exec_defs_pkg::SFR_STATUS,
            8'h01 << exec_defs_pkg::CARRY_BIT);
        chk("cySet", carryFlag, 16'h0001);
        run(8'hA4);
        chk("mulLow", acc, 16'h0000);
        chk("mulHigh", auxReg, 16'h0032);
        chk("mulOv", overflowFlag, 16'h0001);
        chk("mulCy", carryFlag, 16'h0000);
        run(8'hA4);
        chk("mulOvOff", overflowFlag, 16'h0000);
    endtask : tMul
    task automatic tNop();
        t = dataPointer;
        eAcc = acc;
        run(8'h00);
        chk("nopPc", pc, ePc);
        chk("nopAcc", acc, eAcc);
        chk("nopPtr", dataPointer, t);
    endtask : tNop
    task automatic tTbl();
        run(8'h43, 8'hE0, 8'h01);
        run(8'h43, 8'h82, 8'hFF);
        run(8'h93);
        chk("ptrAddr", codeAddr, 16'h0100);
        chk("ptrByte", acc, 16'h005B);
        chk("ptrKeep", dataPointer, 16'h00FF);
        slow = 1'b1;
        t = ePc + 16'h005C;
        run(8'h83);
        eAcc = t[15:8] ^ t[7:0] ^ 8'h5A;
        chk("pcAddr", codeAddr, t);
        chk("pcByte", acc, eAcc);
        chk("pcNext", pc, ePc);
    endtask : tTbl
    task automatic tExt();
        run(8'h43, 8'h83, 8'h12);
        run(8'hF0);
        chk("wrLong", mem.ram[16'h12FF], eAcc);
        chk("latchHi", highPortLatch, 16'h00FF);
        run(8'h43, 8'h80, 8'h0F);
        chk("latchLo", lowPortLatch, 16'h00FF);
        run(8'h44, 8'hFF);
        run(8'hE0);
        chk("rdLong", acc, eAcc);
        run(8'h43, 8'h01, 8'hFF);
        run(8'hF3);
        chk("wrShort", mem.ram[16'hFFFF], eAcc);
        run(8'h44, 8'hFF);
        run(8'hE3);
        chk("rdShort", acc, eAcc);
    endtask : tExt
    task automatic tOr();
        run(8'h43, 8'h08, 8'hFF);
        run(8'h43, 8'hF0, 8'h0F);
        run(8'h45, 8'hF0);
        chk("orDir", acc, eAcc | 8'h0F);
        run(8'h42, 8'hF0);
        chk("orToDir", auxReg, eAcc | 8'h0F);
        run(8'h44, 8'h30);
        chk("orImm", acc, eAcc | 8'h3F);
        run(8'h43, 8'h7F, 8'hFF);
        run(8'h47);
        chk("orInd", acc, 16'h00FF);
        t = 16'h13FE;
        eAcc = t[15:8] ^ t[7:0] ^ 8'h5A;
        run(8'h93);
        chk("ptrCarry", codeAddr, t);
        chk("ptrLoad", acc, eAcc);
        regBank = 2'h1;
        run(8'h48);
        regBank = 2'h0;
        chk("orReg", acc, 16'h00FF);
        chk("orFlags", {carryFlag, overflowFlag}, 16'h0000);
    endtask : tOr
    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stopTest
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            $display("MISMATCH cycles expected %0d seen %0d", 2999, cycles);
            stopTest();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        tMul();
        tNop();
        tTbl();
        tExt();
        tOr();
        stopTest();
    end
endmodule : tb
bind code_ext_mul_or_exec exec_props chk (.clk, .srst, .instrValid,
    .instrReady, .opcode, .acc, .auxReg, .pc, .dataPointer, .carryFlag,
    .overflowFlag, .highPortLatch, .codeRead, .codeAddr, .lowMuxPortOut,
    .lowMuxPortOe, .highAddressPortOut, .addrLatchStrobe);
